// ---- status_enable_and_queues.sv ----
// Purpose: Event enables, status byte summaries, output queue and error queue
// Assumes: APB slave, zero wait states; event and message inputs on i_clock
// Notes:   Command decoding lives in software; this block holds state
//
// Overview of operation
// - Summary bit sets when any event bit is set with its enable bit.
// - Writing zero to an enable register clears all its bits.
// - Enable registers are 16 bits wide, accept up to 65535, read back.
// - Reset and preset clear enables; clear-status leaves them unchanged.
// - Output queue is FIFO; each query response is appended.
// - Message-available bit follows non-empty output queue; reads remove messages.
// - Error-available bit follows non-empty error queue; reads remove messages.
// - Error queue holds ten entries; a read returns and removes the oldest.
// - On filling, the last slot holds code 350 instead of the newest.
// - Reading an empty error queue returns code 0.
// - Entries carry signed code and text; code-only reads exist.
// - Reset admits error codes, excludes status codes; clear and preset keep filter.
// - Enable list replaces admitted set; disable list removes listed codes.
// - Lists hold single codes and inclusive ranges in any combination.
// - Enable with empty list admits nothing.
// - Read-next, drain, count, code-only, list readback and clear operations.
// - Reset and clear-status empty the error queue; preset does not.
// - Event bits latch until read or cleared; reading clears them.
`include "status_queue_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module status_enable_and_queues
    import status_queue_pkg::*;
#(
    parameter int OQ_DEPTH = 8,
    parameter int ERR_DEPTH = `ERRQ_DEPTH,
    parameter int N_RANGES = 4
) (
    input  wire logic               i_clock,
    input  wire logic               i_nrst,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [7:0]         i_paddr,
    input  wire logic [31:0]        i_pwdata,
    output logic      [31:0]        o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    input  wire event_sets_t        i_events,
    input  wire logic               i_resp_valid,
    input  wire logic [31:0]        i_resp_data,
    output logic                    o_resp_ready,
    input  wire logic               i_err_valid,
    input  wire err_entry_t         i_err_entry,
    output logic      [7:0]         o_status_byte
);
    localparam int OCW = $clog2(OQ_DEPTH+1);
    localparam int OPW = $clog2(OQ_DEPTH);
    localparam int ECW = $clog2(ERR_DEPTH+1);
    localparam logic [OCW-1:0] OQ_FULL = OCW'(OQ_DEPTH);
    localparam logic [OPW-1:0] OQ_LAST = OPW'(OQ_DEPTH - 1);

    // APB handshake
    logic               pready_reg;
    logic               pslverr_reg;
    logic [31:0]        prdata_reg;
    logic [31:0]        rd_val;
    logic               rd_ok;
    logic               done;
    logic               wr_done;
    logic               rd_done;
    logic [1:0]         idx;
    logic [7:0]         addr_base;
    logic               had_entry_reg;
    assign done      = i_psel & i_penable & pready_reg;
    assign wr_done   = done & i_pwrite & ~pslverr_reg;
    assign rd_done   = done & ~i_pwrite & ~pslverr_reg;
    assign idx       = i_paddr[3:2];
    assign addr_base = {i_paddr[7:4], 4'h0};

    // Status state
    event_sets_t        enable_reg;
    event_sets_t        event_reg;
    logic [7:0]         stb_reg;
    logic [3:0]         summary;
    logic               cmd_clear_status;
    logic               cmd_preset;

    // Output queue
    logic [31:0]        oq_reg [OQ_DEPTH];
    logic [OPW-1:0]     oq_rd_reg;
    logic [OPW-1:0]     oq_wr_reg;
    logic [OCW-1:0]     oq_cnt_reg;
    logic               oq_push;
    logic               oq_pop;
    logic               resp_ready_reg;

    // Error queue and admission filter
    code_range_t        stage_reg [N_RANGES];
    logic [N_RANGES-1:0] stage_v_reg;
    code_range_t        en_rng_reg [N_RANGES];
    logic [N_RANGES-1:0] en_v_reg;
    code_range_t        dis_rng_reg [N_RANGES];
    logic [N_RANGES-1:0] dis_v_reg;
    logic [N_RANGES-1:0] en_hit;
    logic [N_RANGES-1:0] dis_hit;
    logic               admit;
    err_entry_t         err_head;
    logic [ECW-1:0]     err_cnt;
    logic               err_pop;
    logic               err_clear;

    assign cmd_clear_status = wr_done && i_paddr == `OFS_CTRL && i_pwdata[`CTRL_CLEAR_STATUS];
    assign cmd_preset = wr_done && i_paddr == `OFS_CTRL && i_pwdata[`CTRL_PRESET];

    // Read value formed in the setup cycle, returned in the access cycle
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (i_paddr[1:0] != 2'b00) begin
            rd_ok = 1'b0;
        end else if (i_paddr == `OFS_CTRL) begin
            rd_val = 32'h0000_0000;
        end else if (i_paddr == `OFS_STATUS_BYTE) begin
            rd_val = {24'h00_0000, stb_reg};
        end else if (addr_base == `OFS_ENABLE_BASE) begin
            rd_val = {16'h0000, enable_reg[idx]};
        end else if (addr_base == `OFS_EVENT_BASE) begin
            rd_val = {16'h0000, event_reg[idx]};
        end else if (i_paddr == `OFS_OQ_DATA) begin
            rd_val = (oq_cnt_reg != '0) ? oq_reg[oq_rd_reg] : 32'h0000_0000;
        end else if (i_paddr == `OFS_OQ_COUNT) begin
            rd_val = 32'(oq_cnt_reg);
        end else if (i_paddr == `OFS_ERR_NEXT) begin
            rd_val = (err_cnt != '0) ? err_head : {`CODE_NO_ERROR, 16'h0000};
        end else if (i_paddr == `OFS_ERR_CODE) begin
            rd_val = (err_cnt != '0) ? 32'(err_head.code) : 32'h0000_0000;
        end else if (i_paddr == `OFS_ERR_COUNT) begin
            rd_val = 32'(err_cnt);
        end else if (addr_base == `OFS_STAGE_BASE && 32'(idx) < N_RANGES) begin
            rd_val = stage_reg[idx];
        end else if (i_paddr == `OFS_STAGE_VALID) begin
            rd_val = 32'(stage_v_reg);
        end else if (addr_base == `OFS_EN_LIST && 32'(idx) < N_RANGES) begin
            rd_val = en_rng_reg[idx];
        end else if (addr_base == `OFS_DIS_LIST && 32'(idx) < N_RANGES) begin
            rd_val = dis_rng_reg[idx];
        end else if (i_paddr == `OFS_LIST_VALID) begin
            rd_val = {16'h0000, 8'(dis_v_reg), 8'(en_v_reg)};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            had_entry_reg <= 1'b0;
        end else begin
            pready_reg  <= i_psel & ~i_penable;
            pslverr_reg <= i_psel & ~i_penable & ~rd_ok;
            prdata_reg  <= (i_psel & ~i_penable & rd_ok & ~i_pwrite) ? rd_val : 32'h0000_0000;
            // Pop only what the snapshot returned
            had_entry_reg <= (i_paddr == `OFS_OQ_DATA) ? (oq_cnt_reg != '0) : (err_cnt != '0);
        end
    end

    // Enable registers; only the low 16 bits are kept
    always_ff @(posedge i_clock) begin
        if (!i_nrst || cmd_preset) begin
            enable_reg <= {4{`ENABLE_RESET}};
        end else if (wr_done && addr_base == `OFS_ENABLE_BASE) begin
            enable_reg[idx] <= i_pwdata[15:0];
        end
    end

    // Event bits: a new event wins over the clear of the same cycle
    always_ff @(posedge i_clock) begin
        if (!i_nrst || cmd_clear_status) begin
            event_reg <= i_nrst ? i_events : '0;
        end else begin
            for (int s = 0; s < 4; s++) begin
                if (rd_done && addr_base == `OFS_EVENT_BASE && idx == 2'(s)) begin
                    event_reg[s] <= (event_reg[s] & ~prdata_reg[15:0]) | i_events[s];
                end else begin
                    event_reg[s] <= event_reg[s] | i_events[s];
                end
            end
        end
    end

    // Index 0 standard, 1 operation, 2 measurement, 3 questionable
    always_comb begin
        for (int s = 0; s < 4; s++) begin
            summary[s] = |(event_reg[s] & enable_reg[s]);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            stb_reg <= 8'h00;
        end else begin
            stb_reg                <= 8'h00;
            stb_reg[`STB_STD_SUM]  <= summary[0];
            stb_reg[`STB_OPER_SUM] <= summary[1];
            stb_reg[`STB_MEAS_SUM] <= summary[2];
            stb_reg[`STB_QUES_SUM] <= summary[3];
            stb_reg[`STB_MSG_AVAIL] <= (oq_cnt_reg != '0);
            stb_reg[`STB_ERR_AVAIL] <= (err_cnt != '0);
        end
    end

    // Output queue; a response offered while full waits on o_resp_ready
    assign oq_push = i_resp_valid & resp_ready_reg;
    assign oq_pop  = rd_done && i_paddr == `OFS_OQ_DATA && had_entry_reg;
    always_ff @(posedge i_clock) begin
        if (oq_push) begin
            oq_reg[oq_wr_reg] <= i_resp_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            oq_rd_reg      <= '0;
            oq_wr_reg      <= '0;
            oq_cnt_reg     <= '0;
            resp_ready_reg <= 1'b0;
        end else begin
            if (oq_pop) begin
                oq_rd_reg <= (oq_rd_reg == OQ_LAST) ? '0 : oq_rd_reg + 1'b1;
            end
            if (oq_push) begin
                oq_wr_reg <= (oq_wr_reg == OQ_LAST) ? '0 : oq_wr_reg + 1'b1;
            end
            oq_cnt_reg     <= oq_cnt_reg + OCW'(oq_push) - OCW'(oq_pop);
            resp_ready_reg <= (oq_cnt_reg + OCW'(oq_push) - OCW'(oq_pop)) != OQ_FULL;
        end
    end

    // Admission filter: one comparator pair per list slot
    genvar g;
    generate
        for (g = 0; g < N_RANGES; g++) begin : g_filter
            assign en_hit[g]  = en_v_reg[g] && i_err_entry.code >= en_rng_reg[g].lo
                                && i_err_entry.code <= en_rng_reg[g].hi;
            assign dis_hit[g] = dis_v_reg[g] && i_err_entry.code >= dis_rng_reg[g].lo
                                && i_err_entry.code <= dis_rng_reg[g].hi;
        end
    endgenerate
    assign admit = i_err_valid & (|en_hit) & ~(|dis_hit);

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            stage_v_reg <= '0;
            for (int r = 0; r < N_RANGES; r++) begin
                stage_reg[r] <= '0;
            end
        end else if (wr_done && addr_base == `OFS_STAGE_BASE && 32'(idx) < N_RANGES) begin
            stage_reg[idx] <= i_pwdata;
        end else if (wr_done && i_paddr == `OFS_STAGE_VALID) begin
            stage_v_reg <= i_pwdata[N_RANGES-1:0];
        end
    end

    // Filter survives clear-status and preset; only reset restores it
    // Disable slots are overwritten per index, so at most N_RANGES holes
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            en_v_reg  <= N_RANGES'(4'b0011);
            dis_v_reg <= '0;
            for (int r = 0; r < N_RANGES; r++) begin
                en_rng_reg[r]  <= '0;
                dis_rng_reg[r] <= '0;
            end
            en_rng_reg[0] <= '{hi: `CODE_MINUS_ONE, lo: `CODE_MIN};
            en_rng_reg[1] <= '{hi: `STATUS_CODE_MIN - 16'sd1, lo: `CODE_PLUS_ONE};
        end else if (wr_done && i_paddr == `OFS_CTRL && i_pwdata[`CTRL_LIST_ENABLE]) begin
            en_v_reg  <= stage_v_reg;
            dis_v_reg <= '0;
            for (int r = 0; r < N_RANGES; r++) begin
                en_rng_reg[r] <= stage_reg[r];
            end
        end else if (wr_done && i_paddr == `OFS_CTRL && i_pwdata[`CTRL_LIST_DISABLE]) begin
            dis_v_reg <= dis_v_reg | stage_v_reg;
            for (int r = 0; r < N_RANGES; r++) begin
                if (stage_v_reg[r]) begin
                    dis_rng_reg[r] <= stage_reg[r];
                end
            end
        end
    end

    assign err_pop   = rd_done && had_entry_reg && (i_paddr == `OFS_ERR_NEXT || i_paddr == `OFS_ERR_CODE);
    assign err_clear = cmd_clear_status || (wr_done && i_paddr == `OFS_CTRL &&
                       (i_pwdata[`CTRL_ERR_CLEAR] || i_pwdata[`CTRL_ERR_DRAIN]));
    error_fifo #(
        .DEPTH   (ERR_DEPTH)
    ) u_error_fifo (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_push  (admit),
        .i_entry (i_err_entry),
        .i_pop   (err_pop),
        .i_clear (err_clear),
        .o_head  (err_head),
        .o_count (err_cnt)
    );

    assign o_prdata      = prdata_reg;
    assign o_pready      = pready_reg;
    assign o_pslverr     = pslverr_reg;
    assign o_resp_ready  = resp_ready_reg;
    assign o_status_byte = stb_reg;

    sequence s_ctrl_write(int b);
        i_psel && i_penable && pready_reg && i_pwrite && i_paddr == `OFS_CTRL && i_pwdata[b];
    endsequence

    AST_SUMMARY: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (|(event_reg[2] & enable_reg[2])) |=> stb_reg[`STB_MEAS_SUM]) else $error("summary not set");
    AST_PRESET_EN: assert property (@(posedge i_clock) disable iff (!i_nrst)
        s_ctrl_write(`CTRL_PRESET) |=> enable_reg == '0) else $error("preset kept enables");
    AST_CLEAR_EN: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (s_ctrl_write(`CTRL_CLEAR_STATUS) ##0 !i_pwdata[`CTRL_PRESET]) |=> $stable(enable_reg))
        else $error("clear-status changed enables");
    AST_MSG_AVAIL: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (oq_cnt_reg != '0) |=> stb_reg[`STB_MSG_AVAIL]) else $error("message bit missing");
    AST_ERR_AVAIL: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (err_cnt == '0) |=> !stb_reg[`STB_ERR_AVAIL]) else $error("error bit stuck");
    AST_EMPTY_READ: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_psel && !i_penable && !i_pwrite && i_paddr == `OFS_ERR_NEXT && err_cnt == '0)
        |=> prdata_reg == 32'h0000_0000) else $error("empty read not code 0");
    AST_EMPTY_LIST: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (s_ctrl_write(`CTRL_LIST_ENABLE) ##0 stage_v_reg == '0) |=> en_v_reg == '0 ##1 !admit)
        else $error("empty list still admits");
    AST_CLEAR_ERRQ: assert property (@(posedge i_clock) disable iff (!i_nrst)
        s_ctrl_write(`CTRL_CLEAR_STATUS) |=> err_cnt == '0) else $error("error queue kept");
    AST_STICKY: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_events[1] != '0 && !cmd_clear_status) |=> (event_reg[1] & $past(i_events[1])) == $past(i_events[1]))
        else $error("event lost");
endmodule : status_enable_and_queues
`default_nettype wire

// ---- status_queue_defines.svh ----
// Purpose: Register map, field positions, reset values and codes
// Assumes: APB with 32-bit data, byte addresses
// Notes:   Definitions only
`ifndef STATUS_QUEUE_DEFINES_SVH
`define STATUS_QUEUE_DEFINES_SVH

`define OFS_CTRL        8'h00
`define OFS_STATUS_BYTE 8'h04
`define OFS_ENABLE_BASE 8'h10
`define OFS_EVENT_BASE  8'h20
`define OFS_OQ_DATA     8'h30
`define OFS_OQ_COUNT    8'h34
`define OFS_ERR_NEXT    8'h38
`define OFS_ERR_CODE    8'h3c
`define OFS_ERR_COUNT   8'h40
`define OFS_STAGE_BASE  8'h50
`define OFS_STAGE_VALID 8'h60
`define OFS_EN_LIST     8'h70
`define OFS_DIS_LIST    8'h80
`define OFS_LIST_VALID  8'h90

`define CTRL_CLEAR_STATUS 0
`define CTRL_PRESET       1
`define CTRL_ERR_CLEAR    2
`define CTRL_ERR_DRAIN    3
`define CTRL_LIST_ENABLE  4
`define CTRL_LIST_DISABLE 5

`define STB_MEAS_SUM  0
`define STB_ERR_AVAIL 2
`define STB_QUES_SUM  3
`define STB_MSG_AVAIL 4
`define STB_STD_SUM   5
`define STB_OPER_SUM  7

`define ENABLE_RESET   16'h0000
`define CODE_OVERFLOW  16'sd350
`define CODE_NO_ERROR  16'sd0
`define ERRQ_DEPTH     10
`define CODE_MIN       16'sh8000
`define CODE_MINUS_ONE 16'shffff
`define CODE_PLUS_ONE  16'sh0001
`define STATUS_CODE_MIN 16'sd100

`endif

// ---- status_queue_pkg.sv ----
// Purpose: Shared types of the status and queue block
// Assumes: Constants live in status_queue_defines.svh
// Notes:   Types only
`default_nettype none
package status_queue_pkg;
    typedef struct packed {
        logic signed [15:0] code;
        logic        [15:0] text;
    } err_entry_t;

    typedef struct packed {
        logic signed [15:0] hi;
        logic signed [15:0] lo;
    } code_range_t;

    typedef logic [3:0][15:0] event_sets_t;
endpackage : status_queue_pkg
`default_nettype wire

// ---- error_fifo.sv ----
// Purpose: Error queue storage with overflow marker in the last slot
// Assumes: Push, pop and clear come from logic on the same clock
// Notes:   A pop of an empty queue is ignored; the caller shows code 0
`include "status_queue_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module error_fifo
    import status_queue_pkg::*;
#(
    parameter int DEPTH = `ERRQ_DEPTH
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_nrst,
    input  wire logic                     i_push,
    input  wire err_entry_t               i_entry,
    input  wire logic                     i_pop,
    input  wire logic                     i_clear,
    output err_entry_t                    o_head,
    output logic [$clog2(DEPTH+1)-1:0]    o_count
);
    localparam int CW = $clog2(DEPTH+1);
    localparam int PW = $clog2(DEPTH);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] LAST_CNT = CW'(DEPTH - 1);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    err_entry_t        store_reg [DEPTH];
    logic [PW-1:0]     rd_ptr_reg;
    logic [PW-1:0]     wr_ptr_reg;
    logic [CW-1:0]     count_reg;
    logic              do_pop;
    logic              do_push;
    err_entry_t        wr_entry;

    assign do_pop  = i_pop & (count_reg != '0);
    // Full queue drops everything until a read frees a slot
    assign do_push = i_push & (count_reg != FULL_CNT);
    assign wr_entry = (count_reg == LAST_CNT && !do_pop) ?
                      err_entry_t'{code: `CODE_OVERFLOW, text: 16'h0000} : i_entry;

    always_ff @(posedge i_clock) begin
        if (do_push) begin
            store_reg[wr_ptr_reg] <= wr_entry;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst || i_clear) begin
            rd_ptr_reg <= '0;
            wr_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (do_push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
        end
    end

    assign o_head  = store_reg[rd_ptr_reg];
    assign o_count = count_reg;

    property p_limit;
        @(posedge i_clock) disable iff (!i_nrst) count_reg <= FULL_CNT;
    endproperty
    AST_ERRQ_LIMIT: assert property (p_limit) else $error("error queue above depth");

    property p_ovf;
        @(posedge i_clock) disable iff (!i_nrst)
            (i_push && !i_pop && !i_clear && count_reg == LAST_CNT)
            |=> (count_reg == FULL_CNT && store_reg[$past(wr_ptr_reg)].code == `CODE_OVERFLOW);
    endproperty
    AST_ERRQ_OVF: assert property (p_ovf) else $error("overflow entry missing");

    property p_drop;
        @(posedge i_clock) disable iff (!i_nrst)
            (i_push && !i_pop && !i_clear && count_reg == FULL_CNT) |=> $stable(wr_ptr_reg) && count_reg == FULL_CNT;
    endproperty
    AST_ERRQ_DROP: assert property (p_drop) else $error("push accepted while full");
endmodule : error_fifo
`default_nettype wire

// ---- apb_host_model.sv ----
// Purpose: Host side APB master for the status block
// Assumes: One clock, slave may add wait states
// Notes:   Waits for pready; only the bench watchdog ends a wait
`timescale 1ns/100ps
`default_nettype none
module apb_host_model (
    input  wire logic        i_clock,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    input  wire logic [31:0] i_prdata,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic      [7:0]  o_paddr,
    output logic      [31:0] o_pwdata
);
    initial begin
        {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
    end
    // Request held until pready seen at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge i_clock);
        o_psel <= 1'b1;
        o_pwrite <= wr;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clock);
        o_penable <= 1'b1;
        @(posedge i_clock);
        while (i_pready !== 1'b1) begin
            @(posedge i_clock);
        end
        q = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// ---- status_enable_and_queues_bench.sv ----
// Purpose: Self-checking bench of the status and queue block
// Assumes: Zero wait APB, registered status byte
// Notes:   Queue model in integers and queues
`include "status_queue_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module status_enable_and_queues_bench;
    import status_queue_pkg::*;
    logic        clk, nrst, psel, pen, pwr, rdy, serr, rv, rr, ev, e;
    logic [7:0]  addr, stb;
    logic [31:0] wd, rd, q, rsp, d;
    event_sets_t evs;
    err_entry_t  ent;
    int          n_fail, checks_done, seed, i, k, mode;
    int          eq[$];
    logic [31:0] oq[$];
    status_enable_and_queues dut (.i_clock(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(rd), .o_pready(rdy),
        .o_pslverr(serr), .i_events(evs), .i_resp_valid(rv), .i_resp_data(rsp),
        .o_resp_ready(rr), .i_err_valid(ev), .i_err_entry(ent), .o_status_byte(stb));
    apb_host_model host (.i_clock(clk), .i_pready(rdy), .i_pslverr(serr), .i_prdata(rd),
        .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(addr), .o_pwdata(wd));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        host.xfer(1'b1, a, v, q, e);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        host.xfer(1'b0, a, 32'h0, q, e);
        chk(q, exp, what);
    endtask : rdc
    task automatic push_err(input int c);
        @(posedge clk);
        ev <= 1'b1;
        ent <= '{16'(c), 16'h0};
        @(posedge clk);
        ev <= 1'b0;
        // Filter modes: 0 reset, 1 nothing, 2 only -222
        if (mode == 0 ? (c < 0 || (c > 0 && c < 100)) : (mode == 2 && c == -222))
            if (eq.size() < 9) eq.push_back(c);
            else if (eq.size() == 9) eq.push_back(350);
        repeat (3) @(posedge clk);
    endtask : push_err
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        #400000;
        n_fail++;
        end_sim();
    end
    initial begin
        {nrst, rv, ev, rsp, ent, evs, n_fail, checks_done, mode} = '0;
        seed = 54;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (k = 0; k < 4; k++) rdc(`OFS_ENABLE_BASE + 8'(4 * k), 0, "enable reset");
        chk(stb, 0, "status reset");
        rdc(8'hfc, 0, "unmapped");
        chk(e, 1, "unmapped error");
        for (k = 0; k < 4; k++) begin
            d = $random(seed);
            wr(`OFS_ENABLE_BASE + 8'(4 * k), 32'hffff_ffff);
            rdc(`OFS_ENABLE_BASE + 8'(4 * k), 32'h0000_ffff, "enable max");
            wr(`OFS_ENABLE_BASE + 8'(4 * k), {16'h0, d[15:0]});
            rdc(`OFS_ENABLE_BASE + 8'(4 * k), {16'h0, d[15:0]}, "enable value");
            wr(`OFS_ENABLE_BASE + 8'(4 * k), 0);
            rdc(`OFS_ENABLE_BASE + 8'(4 * k), 0, "enable zero");
        end
        wr(`OFS_ENABLE_BASE + 8'h4, 32'h8);
        @(posedge clk);
        evs[1] <= 16'h0018;
        @(posedge clk);
        evs <= '0;
        repeat (3) @(posedge clk);
        chk(stb[7], 1, "oper summary");
        rdc(`OFS_EVENT_BASE + 8'h4, 32'h18, "event latch");
        rdc(`OFS_EVENT_BASE + 8'h4, 0, "event cleared");
        @(posedge clk);
        evs[1] <= 16'h0010;
        @(posedge clk);
        evs <= '0;
        repeat (3) @(posedge clk);
        chk(stb[7], 0, "masked event");
        for (k = 0; k < 4; k++) wr(`OFS_ENABLE_BASE + 8'(4 * k), 32'h8);
        @(posedge clk);
        evs <= {4{16'h0008}};
        @(posedge clk);
        evs <= '0;
        repeat (3) @(posedge clk);
        chk(stb, (1 << `STB_STD_SUM) | (1 << `STB_OPER_SUM) | (1 << `STB_MEAS_SUM) | (1 << `STB_QUES_SUM),
            "all summaries");
        wr(`OFS_CTRL, 32'h1 << `CTRL_CLEAR_STATUS);
        rdc(`OFS_ENABLE_BASE + 8'h4, 32'h8, "enable after clear");
        wr(`OFS_CTRL, 32'h1 << `CTRL_PRESET);
        rdc(`OFS_ENABLE_BASE + 8'h4, 0, "enable after preset");
        // Responses offered before the host reads them
        for (i = 0; i < 3; i++) begin
            d = $random(seed);
            oq.push_back(d);
            @(posedge clk);
            rv <= 1'b1;
            rsp <= d;
            @(posedge clk);
            while (rr !== 1'b1) @(posedge clk);
            rv <= 1'b0;
        end
        repeat (3) @(posedge clk);
        rdc(`OFS_OQ_COUNT, 3, "out count");
        chk(stb[4], 1, "message available");
        for (i = 0; i < 3; i++) rdc(`OFS_OQ_DATA, oq.pop_front(), "out data");
        repeat (3) @(posedge clk);
        chk(stb[4], 0, "message gone");
        push_err(-110);
        push_err(150);
        push_err(0);
        rdc(`OFS_ERR_COUNT, eq.size(), "filter reset");
        chk(stb[2], 1, "error available");
        rdc(`OFS_ERR_NEXT, {16'hff92, 16'h0}, "oldest");
        void'(eq.pop_front());
        rdc(`OFS_ERR_NEXT, 0, "empty read");
        chk(stb[2], 0, "error gone");
        for (i = 0; i < 12; i++) push_err(-1 - i);
        rdc(`OFS_ERR_COUNT, 10, "full count");
        for (i = 0; i < 11; i++) rdc(`OFS_ERR_CODE, eq.size() ? 32'(eq.pop_front()) : 0, "code");
        push_err(-5);
        wr(`OFS_CTRL, 32'h1 << `CTRL_PRESET);
        rdc(`OFS_ERR_COUNT, 1, "preset keeps");
        wr(`OFS_CTRL, 32'h1 << `CTRL_CLEAR_STATUS);
        rdc(`OFS_ERR_COUNT, 0, "clear status empties");
        push_err(-6);
        push_err(-7);
        wr(`OFS_CTRL, 32'h1 << `CTRL_ERR_DRAIN);
        rdc(`OFS_ERR_COUNT, 0, "drain");
        push_err(-8);
        wr(`OFS_CTRL, 32'h1 << `CTRL_ERR_CLEAR);
        rdc(`OFS_ERR_COUNT, 0, "clear");
        eq.delete();
        wr(`OFS_STAGE_BASE, 32'hff22_ff22);
        wr(`OFS_STAGE_VALID, 1);
        wr(`OFS_CTRL, 32'h1 << `CTRL_LIST_ENABLE);
        mode = 2;
        rdc(`OFS_EN_LIST, 32'hff22_ff22, "list readback");
        push_err(-110);
        push_err(-222);
        rdc(`OFS_ERR_COUNT, eq.size(), "enable list");
        wr(`OFS_CTRL, 32'h1 << `CTRL_LIST_DISABLE);
        mode = 1;
        push_err(-222);
        rdc(`OFS_ERR_COUNT, eq.size(), "disable list");
        wr(`OFS_STAGE_VALID, 0);
        wr(`OFS_CTRL, 32'h1 << `CTRL_LIST_ENABLE);
        push_err(-110);
        rdc(`OFS_ERR_COUNT, eq.size(), "empty list");
        end_sim();
    end
endmodule : status_enable_and_queues_bench
`default_nettype wire
